// file: logic/status_sets_map.svh
// Purpose: constants for the status register sets
// Assumes: included by bare name
// Notes:   set indices, data mask, sensor bit, preset values
`ifndef STATUS_SETS_MAP_SVH
`define STATUS_SETS_MAP_SVH
`define NUM_SETS        13
`define SET_IDX_W       4
`define SET_DEVICE      4'h0
`define SET_OPERATION   4'h1
`define SET_QUESTION    4'h9
`define DATA_MASK       16'h7fff
`define SENSOR_ERR_BIT  3
`define PRESET_ENA_ONES 15'h7fff
`define PRESET_ENA_ZERO 15'h0000
`define PRESET_RISE     15'h7fff
`define PRESET_FALL     15'h0000
`endif

// file: logic/status_sets_pkg.sv
// Purpose: types for the status register sets
// Assumes: nothing
// Notes:   subcommand selects which register of a set is reached
package status_sets_pkg;
   typedef enum logic [2:0] {
      SUB_EVENT     = 3'b000,
      SUB_CONDITION = 3'b001,
      SUB_ENABLE    = 3'b010,
      SUB_FALL      = 3'b011,
      SUB_RISE      = 3'b100
   } subcmd_t;
   typedef enum logic [1:0] {
      CTL_IDLE = 2'b00,
      CTL_ANSW = 2'b01
   } ctl_state_t;
endpackage

// file: logic/status_set.sv
// Purpose: one status register set: event, enable, two filters, summary
// Assumes: condition input is synchronous to sys_clk
// Notes:   bit 15 of every stored register is held at zero
`timescale 1ns/1ps
`include "status_sets_map.svh"
module status_set (
   input  wire logic        sys_clk,
   input  wire logic        power_on,
   input  wire logic        preset,
   input  wire logic        clear_status,
   input  wire logic [14:0] preset_enable,
   input  wire logic [14:0] condition,
   input  wire logic        wr_enable,
   input  wire logic        wr_fall,
   input  wire logic        wr_rise,
   input  wire logic [14:0] wr_data,
   input  wire logic        event_read,
   output logic      [14:0] event_bits,
   output logic      [14:0] enable_bits,
   output logic      [14:0] fall_bits,
   output logic      [14:0] rise_bits,
   output logic             summary
);
   logic [14:0] cond_prev;
   logic [14:0] hit;

   always_ff @(posedge sys_clk) begin
      cond_prev <= power_on ? 15'h0000 : condition;
   end

   generate
      for (genvar i = 0; i < 15; i++) begin : g_bit
         assign hit[i] = (condition[i] & ~cond_prev[i] & rise_bits[i]) |
                         (~condition[i] & cond_prev[i] & fall_bits[i]); // [R16]
      end
   endgenerate

   // a transition in the same cycle as the clearing read is kept
   always_ff @(posedge sys_clk) begin
      if (power_on || clear_status)
         event_bits <= 15'h0000; // [R10]
      else if (event_read)
         event_bits <= hit; // [R2]
      else
         event_bits <= event_bits | hit; // [R16]
   end

   always_ff @(posedge sys_clk) begin
      if (power_on || preset) begin
         enable_bits <= preset_enable; // [R9] [R15]
         fall_bits   <= `PRESET_FALL;
         rise_bits   <= `PRESET_RISE;
      end else begin
         if (wr_enable)
            enable_bits <= wr_data; // [R4]
         if (wr_fall)
            fall_bits <= wr_data; // [R5]
         if (wr_rise)
            rise_bits <= wr_data; // [R6]
      end
   end

   always_ff @(posedge sys_clk) begin
      summary <= power_on ? 1'b0 : |(event_bits & enable_bits); // [R17]
   end

   a_event_latch: assert property (@(posedge sys_clk) disable iff (power_on) // [R16]
      (!clear_status && hit != 15'h0000) |=> ((event_bits & $past(hit)) == $past(hit)))
      else $error("event bit failed to latch");
endmodule

// file: logic/status_sets.sv
// What this block does
// [R1] a condition query returns the selected condition bits, 0..32767, unchanged by the read.
// [R2] an event query returns the selected event bits, 0..32767, then clears that register.
// [R3] a set addressed with no subcommand is handled as an event query with its clearing.
// [R4] an enable write stores the low 15 bits with bit 15 forced to zero.
// [R5] a falling_edge_filter write stores the low 15 bits with bit 15 zero.
// [R6] a rising_edge_filter write stores the low 15 bits with bit 15 zero.
// [R7] enable and filter queries return the stored 15-bit value, 0..32767.
// [R8] the host supplies write values in 0..65535, decimal or not.
// [R9] filters and enables are preset at power-on and by preset, untouched by reset and clear.
// [R10] event registers and the error queue clear on clear-status and power-on only.
// [R11] the error queue enable is preset at power-on and by preset only.
// [R12] the standard event enable and request enable clear at power-on only.
// [R13] the event status and status byte clear on clear-status and power-on only.
// [R14] device set bit 3 follows the sensor EEPROM failure, other bits and bit 15 zero.
// [R15] preset zeros the operation, questionable and device enables, others ones; rise ones, fall zeros.
// [R16] an event bit latches on a filtered rising or falling condition edge.
// [R17] each set reports the OR of its event bits ANDed with its enable bits.
//
// Purpose: thirteen status register sets behind a command port
// Assumes: command strobes come from the text-command parser, already rounded
// Notes:   rst_n stands for power-on; device reset command has no effect here
`timescale 1ns/1ps
`include "status_sets_map.svh"
module status_sets
   import status_sets_pkg::*;
(
   input  wire logic                          sys_clk,
   input  wire logic                          rst_n,
   input  wire logic                          cmd_valid,
   input  wire logic                          cmd_write,
   input  wire logic [`SET_IDX_W-1:0]         cmd_set,
   input  wire status_sets_pkg::subcmd_t      cmd_sub,
   input  wire logic [15:0]                   cmd_data,
   input  wire logic                          cmd_preset,
   input  wire logic                          cmd_clear_status,
   input  wire logic                          cmd_reset,
   input  wire logic                          eeprom_failed,
   input  wire logic [`NUM_SETS*15-1:0]       conditions,
   input  wire logic                          queue_push,
   input  wire logic                          queue_enable_wr,
   input  wire logic                          ieee_enable_wr,
   input  wire logic [7:0]                    ieee_enable_data,
   input  wire logic [7:0]                    ieee_event_set,
   output logic                               rsp_valid,
   output logic      [15:0]                   rsp_data,
   output logic      [`NUM_SETS-1:0]          summaries,
   output logic                               queue_enabled,
   output logic                               queue_pending,
   output logic      [7:0]                    ieee_enable,
   output logic      [7:0]                    ieee_event_status
);
   import status_sets_pkg::*;

   logic              power_on;
   logic [14:0]       cond    [`NUM_SETS];
   logic [14:0]       ev      [`NUM_SETS];
   logic [14:0]       ena     [`NUM_SETS];
   logic [14:0]       fall    [`NUM_SETS];
   logic [14:0]       rise    [`NUM_SETS];
   logic [`NUM_SETS-1:0] summ;
   logic [15:0]       next_rsp;
   logic              sel_ok;
   logic              ev_read_any;
   ctl_state_t        state;

   assign power_on = ~rst_n;
   assign sel_ok   = cmd_set < `SET_IDX_W'(`NUM_SETS);
   // an unrecognised subcommand falls back to the event query
   assign ev_read_any = cmd_valid & ~cmd_write & sel_ok & (cmd_sub != SUB_CONDITION) &
                        (cmd_sub != SUB_ENABLE) & (cmd_sub != SUB_FALL) &
                        (cmd_sub != SUB_RISE); // [R3]

   generate
      for (genvar s = 0; s < `NUM_SETS; s++) begin : g_set
         logic [14:0] pre_ena;
         logic        hit_sel;
         assign hit_sel = cmd_valid & (cmd_set == `SET_IDX_W'(s));
         assign pre_ena = (s == `SET_DEVICE || s == `SET_OPERATION || s == `SET_QUESTION)
                          ? `PRESET_ENA_ZERO : `PRESET_ENA_ONES; // [R15]
         if (s == `SET_DEVICE) begin : g_dev
            // only the sensor error bit is live; the rest read zero
            always_comb begin
               cond[s] = 15'h0000;
               cond[s][`SENSOR_ERR_BIT] = eeprom_failed; // [R14]
            end
         end else begin : g_gen
            assign cond[s] = conditions[s*15 +: 15];
         end
         status_set u_set (
            .sys_clk       (sys_clk),
            .power_on      (power_on),
            .preset        (cmd_preset),
            .clear_status  (cmd_clear_status),
            .preset_enable (pre_ena),
            .condition     (cond[s]),
            .wr_enable     (hit_sel & cmd_write & (cmd_sub == SUB_ENABLE)),
            .wr_fall       (hit_sel & cmd_write & (cmd_sub == SUB_FALL)),
            .wr_rise       (hit_sel & cmd_write & (cmd_sub == SUB_RISE)),
            .wr_data       (cmd_data[14:0]),
            .event_read    (hit_sel & ev_read_any),
            .event_bits    (ev[s]),
            .enable_bits   (ena[s]),
            .fall_bits     (fall[s]),
            .rise_bits     (rise[s]),
            .summary       (summ[s])
         );
      end
   endgenerate

   // bit 15 of the write data is dropped, the host range is wider than storage
   always_comb begin
      next_rsp = 16'h0000;
      if (sel_ok) begin
         case (cmd_sub)
            SUB_CONDITION: next_rsp = {1'b0, cond[cmd_set]}; // [R1]
            SUB_ENABLE:    next_rsp = {1'b0, ena[cmd_set]}; // [R7]
            SUB_FALL:      next_rsp = {1'b0, fall[cmd_set]}; // [R7]
            SUB_RISE:      next_rsp = {1'b0, rise[cmd_set]}; // [R7]
            default:       next_rsp = {1'b0, ev[cmd_set]}; // [R2] [R3]
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state     <= CTL_IDLE;
         rsp_valid <= 1'b0;
         rsp_data  <= 16'h0000;
      end else begin
         case (state)
            CTL_IDLE: begin
               rsp_valid <= cmd_valid & ~cmd_write;
               rsp_data  <= next_rsp & `DATA_MASK;
               if (cmd_valid && !cmd_write)
                  state <= CTL_ANSW;
            end
            CTL_ANSW: begin
               rsp_valid <= cmd_valid & ~cmd_write;
               rsp_data  <= next_rsp & `DATA_MASK;
               if (!(cmd_valid && !cmd_write))
                  state <= CTL_IDLE;
            end
            default: state <= CTL_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      summaries <= rst_n ? summ : '0; // [R17]
   end

   // error queue: clear-status empties it, preset re-enables it
   always_ff @(posedge sys_clk) begin
      if (!rst_n || cmd_clear_status)
         queue_pending <= 1'b0; // [R10]
      else if (queue_push && queue_enabled)
         queue_pending <= 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || cmd_preset)
         queue_enabled <= 1'b1; // [R11]
      else if (queue_enable_wr)
         queue_enabled <= cmd_data[0];
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         ieee_enable <= 8'h00; // [R12]
      else if (ieee_enable_wr)
         ieee_enable <= ieee_enable_data;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || cmd_clear_status)
         ieee_event_status <= 8'h00; // [R13]
      else
         ieee_event_status <= ieee_event_status | ieee_event_set;
   end

   a_cond_answer: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
      (cmd_valid && !cmd_write && sel_ok && cmd_sub == SUB_CONDITION)
      |=> (rsp_valid && rsp_data == {1'b0, $past(cond[cmd_set])}))
      else $error("condition answer wrong");
   a_event_clears: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
      (ev_read_any && cmd_set == `SET_DEVICE && !eeprom_failed && !$past(eeprom_failed))
      |=> (ev[`SET_DEVICE] == 15'h0000))
      else $error("event register not cleared by read");
   a_device_bits: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R14]
      (cond[`SET_DEVICE] == {11'h000, eeprom_failed, 3'b000}))
      else $error("device condition bits wrong");
   a_answer_bit15: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R7]
      rsp_valid |-> !rsp_data[15])
      else $error("answer bit 15 set");
   a_preset_ena: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R15]
      cmd_preset |=> (ena[`SET_OPERATION] == 15'h0000 && ena[2] == 15'h7fff
                      && rise[2] == 15'h7fff && fall[2] == 15'h0000))
      else $error("preset values wrong");
   a_enable_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R4]
      (cmd_valid && cmd_write && cmd_sub == SUB_ENABLE && cmd_set == 4'h2 && !cmd_preset)
      |=> (ena[2] == $past(cmd_data[14:0])))
      else $error("enable write not stored");
   a_clear_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
      (cmd_clear_status && !cmd_preset && !(cmd_valid && cmd_write)) |=> $stable(rise[2]))
      else $error("clear-status altered a filter");
   a_esr_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R13]
      cmd_clear_status |=> (ieee_event_status == 8'h00 && !queue_pending))
      else $error("clear-status did not clear");
   a_ese_keep: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R12]
      (!ieee_enable_wr && (cmd_clear_status || cmd_preset)) |=> $stable(ieee_enable))
      else $error("enable changed by clear or preset");
   a_fall_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R5]
      (cmd_valid && cmd_write && cmd_sub == SUB_FALL && cmd_set == 4'h2 && !cmd_preset)
      |=> (fall[2] == $past(cmd_data[14:0])))
      else $error("falling filter write not stored");
   a_rise_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
      (cmd_valid && cmd_write && cmd_sub == SUB_RISE && cmd_set == 4'h2 && !cmd_preset)
      |=> (rise[2] == $past(cmd_data[14:0])))
      else $error("rising filter write not stored");
   a_event_answer: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
      ev_read_any
      |=> (rsp_valid && rsp_data == {1'b0, $past(ev[cmd_set])}))
      else $error("event answer wrong");
   a_queue_keep: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R11]
      (!cmd_preset && !queue_enable_wr && (cmd_clear_status || cmd_reset))
      |=> $stable(queue_enabled))
      else $error("queue enable changed by clear or reset");
endmodule

// file: test/host_model.sv
// Purpose: remote host issuing status commands to the register sets
// Assumes: one command at a time, driven 1 ns after the rising edge
// Notes:   released set and data lines carry the inverted word, never the old one; write and subcommand hold
`timescale 1ns/1ps
`include "status_sets_map.svh"
module host_model
   import status_sets_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 rsp_valid,
   input  wire logic [15:0]          rsp_data,
   output logic                      cmd_valid,
   output logic                      cmd_write,
   output logic [`SET_IDX_W-1:0]     cmd_set,
   output status_sets_pkg::subcmd_t  cmd_sub,
   output logic [15:0]               cmd_data
);
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_set   = 4'h0;
      cmd_sub   = SUB_EVENT;
      cmd_data  = 16'h0000;
   end
   // parameter is always a whole 16-bit word
   task automatic send(input logic wr, input logic [3:0] s, input logic [2:0] sub,
                       input logic [15:0] d, output logic got, output logic [15:0] rd);
      @(posedge sys_clk);
      #1;
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_set   = s;
      cmd_sub   = subcmd_t'(sub);
      cmd_data  = d;
      @(posedge sys_clk);
      #1;
      got       = rsp_valid;
      rd        = rsp_data;
      cmd_valid = 1'b0;
      cmd_data  = ~d;
      cmd_set   = ~s;
   endtask
endmodule

// file: test/tb_status_sets.sv
// Purpose: self-checking bench for the status register sets
// Assumes: host_model owns the command port
// Notes:   random data from a fixed seed; queue enable written once near the end
`timescale 1ns/1ps
`include "status_sets_map.svh"
module tb_status_sets;
   import status_sets_pkg::*;
   logic         sys_clk, rst_n, cmd_valid, cmd_write, cmd_preset, cmd_clear_status;
   logic         cmd_reset, eeprom_failed, queue_push, queue_enable_wr, ieee_enable_wr;
   logic         rsp_valid, queue_enabled, queue_pending, got;
   logic [3:0]   cmd_set;
   subcmd_t      cmd_sub;
   logic [15:0]  cmd_data, rsp_data, d, rd;
   logic [194:0] conditions;
   logic [12:0]  summaries;
   logic [7:0]   ieee_enable_data, ieee_event_set, ieee_enable, ieee_event_status;
   logic [14:0]  v;
   int           s, i, k, error_cnt = 0, n_checks = 0, cycles = 0;
   status_sets DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_set(cmd_set), .cmd_sub(cmd_sub), .cmd_data(cmd_data),
      .cmd_preset(cmd_preset), .cmd_clear_status(cmd_clear_status), .cmd_reset(cmd_reset),
      .eeprom_failed(eeprom_failed), .conditions(conditions), .queue_push(queue_push),
      .queue_enable_wr(queue_enable_wr), .ieee_enable_wr(ieee_enable_wr),
      .ieee_enable_data(ieee_enable_data), .ieee_event_set(ieee_event_set),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .summaries(summaries),
      .queue_enabled(queue_enabled), .queue_pending(queue_pending),
      .ieee_enable(ieee_enable), .ieee_event_status(ieee_event_status));
   host_model u_host (.sys_clk(sys_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_set(cmd_set),
      .cmd_sub(cmd_sub), .cmd_data(cmd_data));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // run needs well under 2000 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input int st, input int sub, input logic [15:0] dv);
      u_host.send(1'b1, 4'(st), 3'(sub), dv, got, rd);
      check({15'h0, got}, 16'h0000);
   endtask
   task automatic q(input int st, input int sub, input logic [15:0] exp);
      u_host.send(1'b0, 4'(st), 3'(sub), 16'h0000, got, rd);
      check({15'h0, got}, 16'h0001);
      check(rd, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   function automatic logic [15:0] ena_preset(input int st);
      return (st == 0 || st == 1 || st == 9) ? 16'h0000 : 16'h7fff;
   endfunction
   initial begin
      v = 15'($urandom(13656));
      {rst_n, cmd_preset, cmd_clear_status, cmd_reset, eeprom_failed} = '0;
      {queue_push, queue_enable_wr, ieee_enable_wr} = '0;
      ieee_enable_data = 8'h00;
      ieee_event_set = 8'h00;
      conditions = '0;
      repeat (8) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      for (s = 0; s < 13; s++) begin
         q(s, SUB_ENABLE, ena_preset(s));
         q(s, SUB_RISE, 16'h7fff);
         q(s, SUB_FALL, 16'h0000);
      end
      check({15'h0, queue_enabled}, 16'h0001);
      check({8'h0, ieee_enable}, 16'h0000);
      for (i = 0; i < 8; i++) begin
         s = $urandom % 13;
         d = (i == 0) ? 16'hffff : 16'($urandom);
         for (k = 2; k < 5; k++) begin
            wr(s, k, d);
            q(s, k, {1'b0, d[14:0]});
         end
      end
      wr(13, SUB_ENABLE, 16'h1234);
      q(13, SUB_ENABLE, 16'h0000);
      for (s = 1; s < 13; s++) conditions[s*15 +: 15] = v ^ 15'(s);
      eeprom_failed = 1'b1;
      tick(2);
      for (s = 1; s < 13; s++) q(s, SUB_CONDITION, {1'b0, v ^ 15'(s)});
      q(5, SUB_CONDITION, {1'b0, v ^ 15'h0005});
      q(0, SUB_CONDITION, 16'h0008);
      eeprom_failed = 1'b0;
      tick(2);
      q(0, SUB_CONDITION, 16'h0000);
      wr(2, SUB_RISE, 16'h0001);
      wr(2, SUB_FALL, 16'h0002);
      wr(2, SUB_ENABLE, 16'h0003);
      conditions = '0;
      tick(3);
      cmd_clear_status = 1'b1;
      tick(1);
      cmd_clear_status = 1'b0;
      tick(3);
      check({15'h0, summaries[2]}, 16'h0000);
      conditions[30 +: 15] = 15'h0003;
      tick(3);
      check({15'h0, summaries[2]}, 16'h0001);
      q(2, SUB_EVENT, 16'h0001);
      q(2, SUB_EVENT, 16'h0000);
      tick(3);
      check({15'h0, summaries[2]}, 16'h0000);
      conditions[30 +: 15] = 15'h0000;
      tick(3);
      q(2, 5, 16'h0002);
      q(2, SUB_EVENT, 16'h0000);
      conditions[30 +: 15] = 15'h0001;
      tick(3);
      // reset command shares the cycle with preset; it must change nothing
      {cmd_reset, cmd_preset, queue_push, ieee_enable_wr} = 4'hf;
      ieee_event_set = 8'h21;
      ieee_enable_data = 8'ha5;
      tick(1);
      {cmd_reset, cmd_preset, queue_push, ieee_enable_wr} = 4'h0;
      ieee_event_set = 8'h00;
      tick(3);
      check({15'h0, summaries[2]}, 16'h0001);
      q(2, SUB_ENABLE, 16'h7fff);
      q(2, SUB_FALL, 16'h0000);
      check({15'h0, queue_pending}, 16'h0001);
      check({8'h0, ieee_event_status}, 16'h0021);
      cmd_clear_status = 1'b1;
      tick(1);
      cmd_clear_status = 1'b0;
      tick(3);
      check({15'h0, summaries[2]}, 16'h0000);
      check({15'h0, queue_pending}, 16'h0000);
      check({8'h0, ieee_event_status}, 16'h0000);
      check({8'h0, ieee_enable}, 16'h00a5);
      check({15'h0, queue_enabled}, 16'h0001);
      q(2, SUB_ENABLE, 16'h7fff);
      q(2, SUB_EVENT, 16'h0000);
      q(0, SUB_EVENT, 16'h0000);
      eeprom_failed = 1'b1;
      tick(2);
      q(0, SUB_EVENT, 16'h0008);
      // released data word shows bit 0 low after this write
      wr(13, SUB_ENABLE, 16'h0001);
      queue_enable_wr = 1'b1;
      tick(1);
      queue_enable_wr = 1'b0;
      check({15'h0, queue_enabled}, 16'h0000);
      queue_push = 1'b1;
      tick(1);
      queue_push = 1'b0;
      check({15'h0, queue_pending}, 16'h0000);
      {cmd_reset, cmd_clear_status} = 2'b11;
      tick(1);
      {cmd_reset, cmd_clear_status} = 2'b00;
      check({15'h0, queue_enabled}, 16'h0000);
      cmd_preset = 1'b1;
      tick(1);
      cmd_preset = 1'b0;
      check({15'h0, queue_enabled}, 16'h0001);
      end_of_test();
   end
endmodule
